// *** inc/vnps_regs.svh ***
`ifndef VNPS_REGS_SVH
`define VNPS_REGS_SVH

// Operation select codes
`define VNPS_OP_NONE 2'h0
`define VNPS_OP_NEG 2'h1
`define VNPS_OP_PACK 2'h2
`define VNPS_OP_SEARCH 2'h3

// Search mode codes
`define VNPS_MODE_GT 2'h0
`define VNPS_MODE_GE 2'h1
`define VNPS_MODE_LT 2'h2
`define VNPS_MODE_LE 2'h3

// Field positions, widths, pointer step and half-word limits
`define VNPS_HALF_W 16
`define VNPS_HI_LSB 16
`define VNPS_ACC_W 40
`define VNPS_PTR_STEP 32'h0000_0004
`define VNPS_HALF_MAX 16'h7fff
`define VNPS_HALF_MIN 16'h8000

`endif

// *** inc/vnps_pkg.sv ***
package vnps_pkg;
	typedef enum logic [3:0] {
		VNPS_IDLE = 4'h1,
		VNPS_NEG = 4'h2,
		VNPS_PACK = 4'h4,
		VNPS_SRCH = 4'h8
	} vnps_op_e;
	typedef logic [15:0] vnps_half_t;
endpackage

// *** hw/vnps_neg_half.sv ***
`include "vnps_regs.svh"

module vnps_neg_half (
	// Operand
	input wire logic [15:0] i_src,
	// Result and half-word status
	output logic [15:0] o_res,
	output logic o_zero,
	output logic o_neg,
	output logic o_sat,
	output logic o_carry
);
	logic [16:0] diff;

	// Zero minus source in 17 bits; bit 16 clear means no borrow, which is the carry
	assign diff = {1'b0, 16'h0000} - {1'b0, i_src};
	// Only the most negative value overflows; clamp it to the largest positive
	assign o_sat = (i_src == `VNPS_HALF_MIN);
	assign o_res = o_sat ? `VNPS_HALF_MAX : diff[15:0];
	assign o_carry = ~diff[16];
	assign o_zero = (o_res == 16'h0000);
	assign o_neg = o_res[15];
endmodule

// *** hw/vnps_search_lane.sv ***
`include "vnps_regs.svh"

module vnps_search_lane (
	// Inputs
	input wire logic [15:0] i_elem,
	input wire logic [15:0] i_acc_low,
	input wire logic [1:0] i_mode,
	// Decision
	output logic o_take
);
	logic signed [15:0] e;
	logic signed [15:0] a;

	assign e = i_elem;
	assign a = i_acc_low;

	always_comb begin
		unique case (i_mode)
			`VNPS_MODE_GT: o_take = e > a;
			`VNPS_MODE_GE: o_take = e >= a;
			`VNPS_MODE_LT: o_take = e < a;
			`VNPS_MODE_LE: o_take = e <= a;
		endcase
	end
endmodule

// *** hw/vnps_alu.sv ***
`include "vnps_regs.svh"

module vnps_alu #(
	parameter int ACC_W = `VNPS_ACC_W
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Issue
	input wire logic i_valid,
	input wire logic [1:0] i_op,
	input wire logic [1:0] i_search_mode,
	// Pack half selects: 1 picks the upper half
	input wire logic i_pack_sel_a_hi,
	input wire logic i_pack_sel_b_hi,
	// Operands from the register file
	input wire logic [31:0] i_src_a,
	input wire logic [31:0] i_src_b,
	// Parallel slot state
	input wire logic i_par_issue,
	input wire logic i_par_load_p0,
	input wire logic i_par_post_inc,
	// Pointer zero, value before any parallel update
	input wire logic [31:0] i_array_pointer,
	// Accumulators as loaded by other instructions
	input wire logic i_acc_load,
	input wire logic [ACC_W-1:0] i_low_accumulator_in,
	input wire logic [ACC_W-1:0] i_high_accumulator_in,
	// Flag clear from software writes to the status word
	input wire logic i_sticky_clr,
	// Result write-back
	output logic o_res_we,
	output logic [31:0] o_res,
	output logic o_ptr_hi_we,
	output logic o_ptr_lo_we,
	output logic [31:0] o_ptr_hi,
	output logic [31:0] o_ptr_lo,
	output logic o_refused,
	// Accumulators
	output logic [ACC_W-1:0] o_low_accumulator,
	output logic [ACC_W-1:0] o_high_accumulator,
	// Flags
	output logic o_zero_result_flag,
	output logic o_negative_flag,
	output logic o_sat_flag,
	output logic o_sticky_overflow_flag,
	output logic o_carry_flag
);
	vnps_pkg::vnps_op_e op;
	vnps_pkg::vnps_half_t neg_hi;
	vnps_pkg::vnps_half_t neg_lo;
	vnps_pkg::vnps_half_t pack_a;
	vnps_pkg::vnps_half_t pack_b;
	logic z_hi, z_lo, n_hi, n_lo, s_hi, s_lo, c_hi, c_lo;
	logic take_hi, take_lo;
	logic search_ok;
	logic [31:0] cap_ptr;

	function automatic vnps_pkg::vnps_half_t pick_half(input logic [31:0] r, input logic hi);
		pick_half = hi ? r[31:16] : r[15:0];
	endfunction

	function automatic logic [ACC_W-1:0] sext_half(input logic [15:0] h);
		sext_half = {{(ACC_W-16){h[15]}}, h};
	endfunction

	always_comb begin
		op = vnps_pkg::VNPS_IDLE;
		if (i_valid) begin
			unique case (i_op)
				`VNPS_OP_NEG: op = vnps_pkg::VNPS_NEG;
				`VNPS_OP_PACK: op = vnps_pkg::VNPS_PACK;
				`VNPS_OP_SEARCH: op = vnps_pkg::VNPS_SRCH;
				`VNPS_OP_NONE: op = vnps_pkg::VNPS_IDLE;
			endcase
		end
	end

	vnps_neg_half u_neg_hi (
		.i_src(i_src_a[31:16]),
		.o_res(neg_hi),
		.o_zero(z_hi),
		.o_neg(n_hi),
		.o_sat(s_hi),
		.o_carry(c_hi)
	);

	vnps_neg_half u_neg_lo (
		.i_src(i_src_a[15:0]),
		.o_res(neg_lo),
		.o_zero(z_lo),
		.o_neg(n_lo),
		.o_sat(s_lo),
		.o_carry(c_lo)
	);

	// Both lanes share one mode and evaluate in the same cycle
	vnps_search_lane u_lane_hi (
		.i_elem(i_src_a[31:16]),
		.i_acc_low(o_high_accumulator[15:0]),
		.i_mode(i_search_mode),
		.o_take(take_hi)
	);

	vnps_search_lane u_lane_lo (
		.i_elem(i_src_a[15:0]),
		.i_acc_low(o_low_accumulator[15:0]),
		.i_mode(i_search_mode),
		.o_take(take_lo)
	);

	assign pack_a = pick_half(i_src_a, i_pack_sel_a_hi);
	assign pack_b = pick_half(i_src_b, i_pack_sel_b_hi);

	// Anything in the parallel slot other than a pointer-zero load is refused
	assign search_ok = !i_par_issue || i_par_load_p0;
	assign o_refused = (op == vnps_pkg::VNPS_SRCH) && !search_ok;

	// Pointer zero is the implied operand; a parallel post-increment is seen first
	assign cap_ptr = (i_par_issue && i_par_load_p0 && i_par_post_inc) ?
		i_array_pointer + `VNPS_PTR_STEP : i_array_pointer;

	// Data result
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_res_we <= 1'b0;
			o_res <= 32'h0000_0000;
		end else begin
			o_res_we <= (op == vnps_pkg::VNPS_NEG) || (op == vnps_pkg::VNPS_PACK);
			if (op == vnps_pkg::VNPS_NEG)
				o_res <= {neg_hi, neg_lo};
			else if (op == vnps_pkg::VNPS_PACK)
				o_res <= {pack_a, pack_b};
		end
	end

	// Pointer captures
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_ptr_hi_we <= 1'b0;
			o_ptr_lo_we <= 1'b0;
			o_ptr_hi <= 32'h0000_0000;
			o_ptr_lo <= 32'h0000_0000;
		end else begin
			o_ptr_hi_we <= (op == vnps_pkg::VNPS_SRCH) && search_ok && take_hi;
			o_ptr_lo_we <= (op == vnps_pkg::VNPS_SRCH) && search_ok && take_lo;
			if ((op == vnps_pkg::VNPS_SRCH) && search_ok && take_hi)
				o_ptr_hi <= cap_ptr;
			if ((op == vnps_pkg::VNPS_SRCH) && search_ok && take_lo)
				o_ptr_lo <= cap_ptr;
		end
	end

	// Accumulators; a search hit wins over an external load in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_high_accumulator <= '0;
			o_low_accumulator <= '0;
		end else begin
			if ((op == vnps_pkg::VNPS_SRCH) && search_ok && take_hi)
				o_high_accumulator <= sext_half(i_src_a[31:16]);
			else if (i_acc_load)
				o_high_accumulator <= i_high_accumulator_in;
			if ((op == vnps_pkg::VNPS_SRCH) && search_ok && take_lo)
				o_low_accumulator <= sext_half(i_src_a[15:0]);
			else if (i_acc_load)
				o_low_accumulator <= i_low_accumulator_in;
		end
	end

	// Flags change only on negate; pack and search hold them
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_zero_result_flag <= 1'b0;
			o_negative_flag <= 1'b0;
			o_sat_flag <= 1'b0;
			o_carry_flag <= 1'b0;
		end else if (op == vnps_pkg::VNPS_NEG) begin
			o_zero_result_flag <= z_hi | z_lo;
			o_negative_flag <= n_hi | n_lo;
			o_sat_flag <= s_hi | s_lo;
			o_carry_flag <= c_hi | c_lo;
		end
	end

	// Sticky set wins over a clear in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn)
			o_sticky_overflow_flag <= 1'b0;
		else if ((op == vnps_pkg::VNPS_NEG) && (s_hi | s_lo))
			o_sticky_overflow_flag <= 1'b1;
		else if (i_sticky_clr)
			o_sticky_overflow_flag <= 1'b0;
	end

	// Checks
	a_neg_zero_flag: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		op == vnps_pkg::VNPS_NEG |=> o_zero_result_flag ==
			((o_res[31:16] == 16'h0000) || (o_res[15:0] == 16'h0000)))
		else $error("zero flag mismatch");
	a_neg_sign_flag: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		op == vnps_pkg::VNPS_NEG |=> o_negative_flag == (o_res[31] | o_res[15]))
		else $error("negative flag mismatch");
	a_neg_half_sat: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_NEG) && (i_src_a[15:0] == 16'h8000)
		|=> o_res[15:0] == 16'h7fff && o_sat_flag)
		else $error("negate did not saturate");
	a_neg_value: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_NEG) && (i_src_a[31:16] != 16'h8000)
		|=> o_res[31:16] == 16'(-$past(i_src_a[31:16])))
		else $error("upper negate wrong");
	a_sticky_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		o_sat_flag && $rose(o_sat_flag) |-> o_sticky_overflow_flag)
		else $error("sticky not set");
	a_flags_kept: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		op != vnps_pkg::VNPS_NEG |=> $stable(o_carry_flag) && $stable(o_zero_result_flag))
		else $error("flags moved outside negate");
	a_pack_order: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		op == vnps_pkg::VNPS_PACK |=> o_res_we && o_res == {$past(pack_a), $past(pack_b)})
		else $error("pack order wrong");
	a_srch_refuse: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		o_refused |=> !o_ptr_hi_we && !o_ptr_lo_we && $stable(o_high_accumulator))
		else $error("refused search updated state");
	a_srch_sext: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		o_ptr_lo_we |-> o_low_accumulator[ACC_W-1:15] == '0 ||
			o_low_accumulator[ACC_W-1:15] == '1)
		else $error("accumulator not sign-extended");
	a_srch_ptr_inc: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_SRCH) && i_par_issue && i_par_load_p0 && i_par_post_inc && take_hi
		|=> o_ptr_hi == $past(i_array_pointer) + 32'h4)
		else $error("pointer not post-incremented");

	// Negate arithmetic and flags
	a_neg_hi_sat: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_NEG) && (i_src_a[31:16] == 16'h8000)
		|=> o_res[31:16] == 16'h7fff && o_sat_flag)
		else $error("upper negate did not saturate");
	a_neg_lo_value: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_NEG) && (i_src_a[15:0] != 16'h8000)
		|=> o_res[15:0] == 16'(-$past(i_src_a[15:0])))
		else $error("lower negate wrong");
	a_neg_sat_flag: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		op == vnps_pkg::VNPS_NEG |=> o_sat_flag ==
			(($past(i_src_a[31:16]) == 16'h8000) || ($past(i_src_a[15:0]) == 16'h8000)))
		else $error("saturation flag mismatch");
	a_neg_carry: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		op == vnps_pkg::VNPS_NEG |=> o_carry_flag ==
			(($past(i_src_a[31:16]) == 16'h0000) || ($past(i_src_a[15:0]) == 16'h0000)))
		else $error("carry flag mismatch");
	a_sticky_set: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_NEG) && (s_hi | s_lo)
		|=> o_sticky_overflow_flag)
		else $error("sticky not set by saturation");
	a_sticky_keep: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		!((op == vnps_pkg::VNPS_NEG) && (s_hi | s_lo)) && !i_sticky_clr
		|=> $stable(o_sticky_overflow_flag))
		else $error("sticky moved without cause");

	// Pack
	a_pack_hi_sel: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_PACK) && i_pack_sel_a_hi
		|=> o_res[31:16] == $past(i_src_a[31:16]))
		else $error("pack upper select wrong");
	a_pack_lo_sel: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_PACK) && !i_pack_sel_b_hi
		|=> o_res[15:0] == $past(i_src_b[15:0]))
		else $error("pack lower select wrong");
	a_pack_flags: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		op == vnps_pkg::VNPS_PACK |=> $stable(o_sat_flag) && $stable(o_negative_flag)
			&& $stable(o_zero_result_flag))
		else $error("pack moved flags");
	a_res_we_src: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		o_res_we |-> ($past(op) == vnps_pkg::VNPS_NEG) ||
			($past(op) == vnps_pkg::VNPS_PACK))
		else $error("result strobe without negate or pack");

	// Search
	a_srch_hi_acc: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_SRCH) && search_ok && take_hi
		|=> o_ptr_hi_we && o_high_accumulator[15:0] == $past(i_src_a[31:16]))
		else $error("upper search update wrong");
	a_srch_lo_acc: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_SRCH) && search_ok && take_lo
		|=> o_ptr_lo_we && o_low_accumulator[15:0] == $past(i_src_a[15:0]))
		else $error("lower search update wrong");
	a_srch_ptr_plain: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_SRCH) && !i_par_issue && take_lo
		|=> o_ptr_lo == $past(i_array_pointer))
		else $error("pointer capture wrong");
	a_srch_miss: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_SRCH) && !take_hi
		|=> !o_ptr_hi_we)
		else $error("upper lane captured on a miss");
	a_srch_sext_hi: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		o_ptr_hi_we |-> o_high_accumulator[ACC_W-1:15] == '0 ||
			o_high_accumulator[ACC_W-1:15] == '1)
		else $error("upper accumulator not sign-extended");
	a_srch_flags: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		op == vnps_pkg::VNPS_SRCH |=> $stable(o_sat_flag) && $stable(o_negative_flag)
			&& $stable(o_carry_flag))
		else $error("search moved flags");
	a_srch_no_res: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		op == vnps_pkg::VNPS_SRCH |=> !o_res_we)
		else $error("search wrote a data result");
	a_refuse_cond: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op == vnps_pkg::VNPS_SRCH) && i_par_issue && !i_par_load_p0 |-> o_refused)
		else $error("illegal pairing not refused");
	a_refuse_lo: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		o_refused |=> $stable(o_low_accumulator) && $stable(o_ptr_lo))
		else $error("refused search moved lower lane");
	a_acc_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(op != vnps_pkg::VNPS_SRCH) && !i_acc_load
		|=> $stable(o_high_accumulator) && $stable(o_low_accumulator))
		else $error("accumulator moved without cause");
	a_ptr_hi_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		!o_ptr_hi_we |-> $stable(o_ptr_hi))
		else $error("upper pointer moved without strobe");
	a_ptr_lo_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		!o_ptr_lo_we |-> $stable(o_ptr_lo))
		else $error("lower pointer moved without strobe");

	c_neg_sat: cover property (@(posedge i_core_clk) op == vnps_pkg::VNPS_NEG && s_hi && s_lo);
	c_pack: cover property (@(posedge i_core_clk) op == vnps_pkg::VNPS_PACK);
	c_srch_both: cover property (@(posedge i_core_clk) o_ptr_hi_we && o_ptr_lo_we);
	c_srch_par: cover property (@(posedge i_core_clk) op == vnps_pkg::VNPS_SRCH && i_par_post_inc);
	c_sticky_clr: cover property (@(posedge i_core_clk) i_sticky_clr && o_sticky_overflow_flag);
endmodule

// *** dv/vnps_core_model.sv ***
module vnps_core_model #(
	parameter logic [31:0] BASE = 32'h0000_1000
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Parallel load through pointer zero with post increment
	input wire logic i_step,
	// Pointer zero before this cycle's update
	output logic [31:0] o_pointer
);
	timeunit 1ns;
	timeprecision 1ps;
	// The load bumps the pointer after the edge, so the search is given the old value and adds the step itself
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_pointer <= BASE;
		end else if (i_step) begin
			o_pointer <= o_pointer + 32'h0000_0004;
		end
	end
endmodule

// *** dv/vector_negate_pack_search_alu_tb.sv ***
`include "vnps_regs.svh"

module vector_negate_pack_search_alu_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [1:0] op;
		logic sa;
		logic sb;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] r;
		logic [4:0] f;
	} vnps_row_s;
	logic clk = 1'b0, rstn = 1'b0, v = 1'b0, sa = 1'b0, sb = 1'b0, par = 1'b0, p0 = 1'b0;
	logic inc = 1'b0, al = 1'b0, clr = 1'b0;
	logic [1:0] op = 2'h0, md = 2'h0;
	logic [31:0] a = 32'h0, b = 32'h0, p;
	logic [39:0] lo_in = 40'h0, hi_in = 40'h0;
	logic we, phwe, plwe, rf, z, n, s, st, c;
	logic [31:0] res, ph, pl, ptr;
	logic [39:0] lacc, hacc;
	int err_count = 0, num_checks = 0;
	// Flags column is {zero, negative, sat, sticky, carry}; pack rows keep the last one
	vnps_row_s rows [7] = '{
		'{`VNPS_OP_NEG, 1'b0, 1'b0, 32'h0004_7fff, 32'h0, 32'hfffc_8001, 5'h08},
		'{`VNPS_OP_PACK, 1'b0, 1'b0, 32'hdead_1234, 32'hbeef_5678, 32'h1234_5678, 5'h08},
		'{`VNPS_OP_PACK, 1'b1, 1'b1, 32'hdead_1234, 32'hbeef_5678, 32'hdead_beef, 5'h08},
		'{`VNPS_OP_NEG, 1'b0, 1'b0, 32'h8000_0000, 32'h0, 32'h7fff_0000, 5'h17},
		'{`VNPS_OP_PACK, 1'b1, 1'b0, 32'hdead_1234, 32'hbeef_5678, 32'hdead_5678, 5'h17},
		'{`VNPS_OP_NEG, 1'b0, 1'b0, 32'h0001_0001, 32'h0, 32'hffff_ffff, 5'h0a},
		'{`VNPS_OP_PACK, 1'b0, 1'b1, 32'hdead_1234, 32'hbeef_5678, 32'h1234_beef, 5'h0a}
	};

	vnps_alu vnps_alu_inst (.i_core_clk(clk), .i_rstn(rstn), .i_valid(v), .i_op(op),
		.i_search_mode(md), .i_pack_sel_a_hi(sa), .i_pack_sel_b_hi(sb), .i_src_a(a),
		.i_src_b(b), .i_par_issue(par), .i_par_load_p0(p0), .i_par_post_inc(inc),
		.i_array_pointer(ptr), .i_acc_load(al), .i_low_accumulator_in(lo_in),
		.i_high_accumulator_in(hi_in), .i_sticky_clr(clr), .o_res_we(we), .o_res(res),
		.o_ptr_hi_we(phwe), .o_ptr_lo_we(plwe), .o_ptr_hi(ph), .o_ptr_lo(pl), .o_refused(rf),
		.o_low_accumulator(lacc), .o_high_accumulator(hacc), .o_zero_result_flag(z),
		.o_negative_flag(n), .o_sat_flag(s), .o_sticky_overflow_flag(st), .o_carry_flag(c));

	vnps_core_model vnps_core_model_inst (.i_core_clk(clk), .i_rstn(rstn),
		.i_step(v & p0 & inc), .o_pointer(ptr));

	initial begin
		forever #2 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One issue cycle; outputs are settled at the following falling edge
	task automatic go();
		v = 1'b1;
		@(negedge clk);
		v = 1'b0;
		par = 1'b0;
		p0 = 1'b0;
		inc = 1'b0;
	endtask

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#4000;
		err_count++;
		give_verdict();
	end

	initial begin
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		chk("reset outputs", 40'h0, {z, n, s, st, c, we, phwe, plwe});
		$display("Reset test done");
		foreach (rows[i]) begin
			{op, sa, sb, a, b} = {rows[i].op, rows[i].sa, rows[i].sb, rows[i].a, rows[i].b};
			go();
			chk("result", {8'h0, rows[i].r}, res);
			chk("flags", {35'h0, rows[i].f}, {z, n, s, st, c});
			chk("result strobe", 40'h1, we);
		end
		$display("Table test done");
		for (int m = 0; m < 4; m++) begin
			{lo_in, hi_in, al} = {40'h5, 40'h5, 1'b1};
			@(negedge clk);
			al = 1'b0;
			{op, md, a} = {`VNPS_OP_SEARCH, m[1:0], 32'h0005_fffe};
			{par, p0, inc} = {3{m[0]}};
			p = ptr + (m[0] ? 32'h4 : 32'h0);
			go();
			chk("hi capture", m[0], phwe);
			chk("lo capture", m[1], plwe);
			chk("lo acc", m[1] ? 40'hff_ffff_fffe : 40'h5, lacc);
			chk("hi acc", 40'h5, hacc);
			if (m[0]) chk("hi pointer", p, ph);
			if (m[1]) chk("lo pointer", p, pl);
			chk("flags kept", 40'h0a, {z, n, s, st, c});
		end
		{md, a, p} = {`VNPS_MODE_GT, 32'h0006_ffff, ptr};
		go();
		chk("chained hi acc", 40'h6, hacc);
		chk("chained lo acc", 40'hff_ffff_ffff, lacc);
		chk("chained hi pointer", {8'h0, p}, ph);
		chk("chained lo pointer", {8'h0, p}, pl);
		$display("Search test done");
		{a, par, p0, v} = {32'h7fff_7fff, 1'b1, 1'b0, 1'b1};
		#1 chk("refused", 40'h1, rf);
		@(negedge clk);
		{v, par} = 2'b00;
		chk("refused no capture", 40'h0, {phwe, plwe});
		chk("refused acc", 40'h6, hacc);
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		chk("sticky clear", 40'h0, st);
		{op, a, clr} = {`VNPS_OP_NEG, 32'h0000_8000, 1'b1};
		go();
		clr = 1'b0;
		chk("sticky set wins", 40'h1, st);
		chk("low saturate", {8'h0, 32'h0000_7fff}, res);
		$display("Refusal and clear test done");
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		chk("mid reset", 40'h0, {z, n, s, st, c, we, phwe, plwe});
		chk("mid reset acc", 40'h0, hacc);
		$display("Mid reset test done");
		give_verdict();
	end
endmodule
